// >>> hdl/wdt_timer.sv
// Contract
// - the counter advances on rising edges of the slow rc oscillator, not on the system clock.
// - the timeout select field picks a period of 2^8,2^10,2^12,2^14,2^15,2^16,2^17 or 2^18 slow cycles.
// - the watchdog runs whenever the key field holds 01010b or 10101b, and nothing disables it.
// - any other key value causes a full device reset two to three slow cycles later.
// - that key-fault reset sets bit 0 of the reset cause flags.
// - the key-fault flag is only set by hardware and only cleared by power-on or by software writing zero.
// - after power-on the key field holds 01010b so the watchdog starts running.
// - in normal running an overflow causes a full device reset and sets the timeout flag.
// - in sleep or idle an overflow sets the timeout flag and resets only pc and stack pointer.
// - a key-fault reset, the clear instruction or the power-down instruction clears the counter.
// - only the clear instruction and the power-down instruction clear the counter from software; register writes do not.
// - the power-down instruction sets the power-down flag, clears the timeout flag and clears the counter.
// - the power-down flag clears on power-up or on the clear instruction.
//
// Design decisions made here: the strobed register port and the register offsets.
`timescale 1ns/1ps
module wdt_timer
(
    input  wire logic       clk_i,
    input  wire logic       sys_rst_i,
    input  wire logic       por_i,
    input  wire logic       slow_rc_osc_i,
    input  wire logic       counter_clear_instruction_i,
    input  wire logic       power_down_instruction_i,
    input  wire logic       low_power_mode_i,
    input  wire logic [3:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output logic      [7:0] rdata_o,
    output logic            device_reset_o,
    output logic            pc_sp_reset_o,
    output logic            overflow_status_flag_o,
    output logic            power_down_flag_o
);
    // period select decode, used only by the overflow compare
    function automatic logic [wdt_pkg::CNT_W-1:0] period_last(input logic [2:0] sel);
        logic [4:0] sh;
        sh = 5'd0;
        unique case (sel)
            3'h0: sh = 5'd8;
            3'h1: sh = 5'd10;
            3'h2: sh = 5'd12;
            3'h3: sh = 5'd14;
            3'h4: sh = 5'd15;
            3'h5: sh = 5'd16;
            3'h6: sh = 5'd17;
            3'h7: sh = 5'd18;
        endcase
        period_last = wdt_pkg::CNT_W'((19'h0_0001 << sh) - 19'h0_0001);
    endfunction : period_last

    function automatic logic key_ok(input logic [4:0] k);
        key_ok = (k == wdt_pkg::KEY_VALID_A) || (k == wdt_pkg::KEY_VALID_B);
    endfunction : key_ok

    // slow oscillator synchroniser: three stages, a change counts when 2 and 3 agree
    logic [2:0] osc_sync_q;
    logic [2:0] osc_sync_d;
    logic       osc_level_q;
    logic       osc_level_d;
    logic       slow_tick;

    // registers
    logic [7:0]                control_q;
    logic [7:0]                control_d;
    logic                      key_fault_q;
    logic                      key_fault_d;
    logic                      to_q;
    logic                      to_d;
    logic                      pdf_q;
    logic                      pdf_d;
    logic [wdt_pkg::CNT_W-1:0] cnt_q;
    logic [wdt_pkg::CNT_W-1:0] cnt_d;
    logic [1:0]                fault_cnt_q;
    logic [1:0]                fault_cnt_d;
    logic                      dev_rst_q;
    logic                      dev_rst_d;
    logic                      pcsp_q;
    logic                      pcsp_d;
    logic [7:0]                rdata_q;
    logic [7:0]                rdata_d;

    logic                      key_bad;
    logic                      overflow;
    logic                      fault_fire;

    always_comb
    begin
        osc_sync_d  = {osc_sync_q[1:0], slow_rc_osc_i};
        osc_level_d = osc_level_q;
        if (osc_sync_q[1] == osc_sync_q[2])
        begin
            osc_level_d = osc_sync_q[2];
        end
        slow_tick = osc_level_d & ~osc_level_q;
    end

    always_comb
    begin
        key_bad    = ~key_ok(control_q[wdt_pkg::KEY_MSB:wdt_pkg::KEY_LSB]);
        // fault timer counts two full slow edges, landing 2 to 3 slow cycles after the bad write
        fault_fire = key_bad && slow_tick && (fault_cnt_q == wdt_pkg::KEY_DELAY_LAST);
        overflow   = slow_tick && (cnt_q == period_last(control_q[wdt_pkg::SEL_MSB:wdt_pkg::SEL_LSB]));

        fault_cnt_d = fault_cnt_q;
        if (!key_bad)
        begin
            fault_cnt_d = 2'h0;
        end
        else if (slow_tick && fault_cnt_q != wdt_pkg::KEY_DELAY_LAST)
        begin
            fault_cnt_d = fault_cnt_q + 2'h1;
        end

        cnt_d = cnt_q;
        if (fault_fire || counter_clear_instruction_i || power_down_instruction_i || overflow)
        begin
            cnt_d = '0;
        end
        else if (slow_tick)
        begin
            cnt_d = cnt_q + wdt_pkg::CNT_W'(1);
        end

        control_d = control_q;
        if (wr_i && addr_i == wdt_pkg::ADDR_CONTROL)
        begin
            control_d = wdata_i;
        end

        // set beats a simultaneous software clear
        key_fault_d = key_fault_q;
        if (wr_i && addr_i == wdt_pkg::ADDR_CAUSE_FLAGS && !wdata_i[wdt_pkg::KEY_FAULT_BIT])
        begin
            key_fault_d = 1'b0;
        end
        if (fault_fire)
        begin
            key_fault_d = 1'b1;
        end

        to_d  = to_q;
        pdf_d = pdf_q;
        if (counter_clear_instruction_i)
        begin
            pdf_d = 1'b0;
        end
        if (power_down_instruction_i)
        begin
            pdf_d = 1'b1;
            to_d  = 1'b0;
        end
        if (overflow)
        begin
            to_d = 1'b1;
        end

        dev_rst_d = fault_fire || (overflow && !low_power_mode_i);
        pcsp_d    = overflow && low_power_mode_i;

        rdata_d = 8'h00;
        if (rd_i)
        begin
            unique case (addr_i)
                wdt_pkg::ADDR_CONTROL:     rdata_d = control_q;
                wdt_pkg::ADDR_CAUSE_FLAGS: rdata_d[wdt_pkg::KEY_FAULT_BIT] = key_fault_q;
                wdt_pkg::ADDR_STATUS:
                begin
                    rdata_d[wdt_pkg::STAT_TO_BIT]  = to_q;
                    rdata_d[wdt_pkg::STAT_PDF_BIT] = pdf_q;
                end
                default:                   rdata_d = 8'h00;
            endcase
        end
    end

    // device reset (sys_rst_i) clears the count and fault timer; only power-on restores the
    // key and flags, so a key fault repeats after each device reset until software rewrites the key
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            cnt_q       <= '0;
            fault_cnt_q <= 2'h0;
            dev_rst_q   <= 1'b0;
            pcsp_q      <= 1'b0;
            rdata_q     <= 8'h00;
        end
        else
        begin
            cnt_q       <= cnt_d;
            fault_cnt_q <= fault_cnt_d;
            dev_rst_q   <= dev_rst_d;
            pcsp_q      <= pcsp_d;
            rdata_q     <= rdata_d;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (por_i)
        begin
            // the oscillator level survives a device reset so no false tick follows it
            osc_sync_q  <= 3'h0;
            osc_level_q <= 1'b0;
            control_q   <= wdt_pkg::CONTROL_RESET;
            key_fault_q <= 1'b0;
            to_q        <= 1'b0;
            pdf_q       <= 1'b0;
        end
        else
        begin
            osc_sync_q  <= osc_sync_d;
            osc_level_q <= osc_level_d;
            control_q   <= control_d;
            key_fault_q <= key_fault_d;
            to_q        <= to_d;
            pdf_q       <= pdf_d;
        end
    end

    assign rdata_o                = rdata_q;
    assign device_reset_o         = dev_rst_q;
    assign pc_sp_reset_o          = pcsp_q;
    assign overflow_status_flag_o = to_q;
    assign power_down_flag_o      = pdf_q;
endmodule : wdt_timer

// >>> hdl/wdt_pkg.sv
package wdt_pkg;
    // register indices on the plain port (no offsets are printed for these)
    localparam logic [3:0] ADDR_CONTROL     = 4'h0;
    localparam logic [3:0] ADDR_CAUSE_FLAGS = 4'h1;
    localparam logic [3:0] ADDR_STATUS      = 4'h2;

    // control register layout
    localparam int         KEY_MSB          = 7;
    localparam int         KEY_LSB          = 3;
    localparam int         SEL_MSB          = 2;
    localparam int         SEL_LSB          = 0;
    localparam logic [7:0] CONTROL_RESET    = 8'h53;
    localparam logic [4:0] KEY_VALID_A      = 5'h0A;
    localparam logic [4:0] KEY_VALID_B      = 5'h15;

    // reset cause flags layout
    localparam int         KEY_FAULT_BIT    = 0;

    // status register layout
    localparam int         STAT_TO_BIT      = 0;
    localparam int         STAT_PDF_BIT     = 1;

    // counter and timing
    localparam int         CNT_W            = 18;
    localparam int         KEY_DELAY_TICKS  = 2;
    localparam logic [1:0] KEY_DELAY_LAST   = 2'h2;
endpackage : wdt_pkg

// >>> bench/wdt_timer_assertions.sv
`timescale 1ns/1ps
module wdt_timer_assertions
(
    input wire logic       clk_i,
    input wire logic       sys_rst_i,
    input wire logic       por_i,
    input wire logic       slow_rc_osc_i,
    input wire logic       counter_clear_instruction_i,
    input wire logic       power_down_instruction_i,
    input wire logic       low_power_mode_i,
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic       wr_i,
    input wire logic       rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic       device_reset_o,
    input wire logic       pc_sp_reset_o,
    input wire logic       overflow_status_flag_o,
    input wire logic       power_down_flag_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i || por_i);
    // device_reset_o feeds sys_rst_i, so these two may only stop on por_i
    property p_pulse; disable iff (por_i) device_reset_o |=> !device_reset_o; endproperty
    a_pulse: assert property (p_pulse) else $error("device reset longer than one cycle");
    property p_to_rise; disable iff (por_i)
        $rose(overflow_status_flag_o) |-> ##[0:1] (device_reset_o || pc_sp_reset_o); endproperty
    a_to_rise: assert property (p_to_rise) else $error("timeout flag without reset");
    property p_pd; power_down_instruction_i |=> power_down_flag_o; endproperty
    a_pd: assert property (p_pd) else $error("power down flag not set");
    property p_clr; counter_clear_instruction_i && !power_down_instruction_i |=> !power_down_flag_o; endproperty
    a_clr: assert property (p_clr) else $error("power down flag not cleared");
    property p_to_fall; $fell(overflow_status_flag_o) |-> $past(power_down_instruction_i); endproperty
    a_to_fall: assert property (p_to_fall) else $error("timeout flag fell without halt");
    property p_pdf_rise; $rose(power_down_flag_o) |-> $past(power_down_instruction_i); endproperty
    a_pdf_rise: assert property (p_pdf_rise) else $error("power down flag rose without halt");
    property p_pdf_fall; $fell(power_down_flag_o) |-> $past(counter_clear_instruction_i); endproperty
    a_pdf_fall: assert property (p_pdf_fall) else $error("power down flag fell without clear");
    property p_lp; pc_sp_reset_o |-> low_power_mode_i && !device_reset_o; endproperty
    a_lp: assert property (p_lp) else $error("partial reset outside low power");
    c_full: cover property (device_reset_o);
    c_part: cover property (pc_sp_reset_o);
    c_pdclr: cover property (power_down_flag_o && counter_clear_instruction_i);
endmodule : wdt_timer_assertions
bind wdt_timer wdt_timer_assertions wdt_timer_assertions_inst (.*);

// >>> bench/tb.sv
`timescale 1ns/1ps
module tb;
    logic       clk = 0, rst_q = 1, por = 1, osc = 0, clr = 0, pd = 0, lp = 0, wr = 0, rd = 0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    logic       dev_rst, pcsp, to_f, pd_f;
    wire        sys_rst = rst_q | dev_rst;
    int         err_total = 0;
    int         checks = 0;
    wdt_timer wdt_timer_inst (.clk_i(clk), .sys_rst_i(sys_rst), .por_i(por), .slow_rc_osc_i(osc),
        .counter_clear_instruction_i(clr), .power_down_instruction_i(pd), .low_power_mode_i(lp),
        .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .device_reset_o(dev_rst),
        .pc_sp_reset_o(pcsp), .overflow_status_flag_o(to_f), .power_down_flag_o(pd_f));
    initial forever #5 clk = ~clk;
    // slow oscillator at 20 system cycles so the long periods stay short
    initial forever #100 osc = ~osc;
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin err_total++; $display("Error %s expected %0h seen %0h", n, e, g); end
    endtask : chk
    task wrr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk) {addr, wdata, wr} <= {a, d, 1'b1};
        @(posedge clk) wr <= 0;
    endtask : wrr
    task rdc(input logic [3:0] a, input logic [7:0] e, input string n);
        @(posedge clk) {addr, rd} <= {a, 1'b1};
        @(posedge clk) rd <= 0;
        #1 chk(n, e, rdata);
    endtask : rdc
    task pls(input bit c);
        @(posedge clk) {clr, pd} <= {c, !c};
        @(posedge clk) {clr, pd} <= 2'b00;
    endtask : pls
    // waits for either reset pulse, then judges the delay in cycles and which pulse came
    task wt(input int lo, input int hi, input logic full);
        int n;
        logic k;
        n = 0;
        while (!(dev_rst || pcsp) && n < 30000) begin @(posedge clk); #1; n++; end
        k = dev_rst;
        chk("delay in window", 1, n >= lo && n <= hi);
        chk("reset kind", full, k);
    endtask : wt
    task t_reset;
        rdc(4'h0, 8'h53, "control");
        rdc(4'h1, 8'h00, "cause");
        rdc(4'h2, 8'h00, "status");
        wrr(4'hF, 8'hFF);
        rdc(4'hF, 8'h00, "unmapped");
        rdc(4'h0, 8'h53, "control kept");
        $display("reset test done");
    endtask : t_reset
    task t_ovf(input logic [2:0] s, input int t);
        wrr(4'h0, {5'h0A, s});
        pls(1);
        repeat (2000) @(posedge clk);
        pls(1);
        wt((t - 2) * 20, (t + 1) * 20, 1);
        rdc(4'h2, 8'h01, "status after overflow");
        $display("overflow test done");
    endtask : t_ovf
    task t_lp;
        wrr(4'h0, 8'h50);
        @(posedge clk) lp <= 1;
        pls(0);
        rdc(4'h2, 8'h02, "status after halt");
        wt(254 * 20, 257 * 20, 0);
        rdc(4'h2, 8'h03, "status after wake");
        @(posedge clk) lp <= 0;
        pls(1);
        rdc(4'h2, 8'h01, "status after clear");
        $display("low power test done");
    endtask : t_lp
    task t_key;
        wrr(4'h0, 8'hF8);
        wt(30, 90, 1);
        wrr(4'h0, 8'hA8);
        rdc(4'h1, 8'h01, "key fault flag");
        wrr(4'h1, 8'h01);
        rdc(4'h1, 8'h01, "flag after one");
        wrr(4'h1, 8'h00);
        rdc(4'h1, 8'h00, "flag after zero");
        rdc(4'h0, 8'hA8, "control second key");
        $display("key test done");
    endtask : t_key
    task results;
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : results
    initial
    begin
        repeat (3) @(posedge clk);
        {rst_q, por} <= 2'b00;
        t_reset;
        t_ovf(3'h0, 256);
        t_ovf(3'h1, 1024);
        t_lp;
        t_key;
        results;
    end
    initial
    begin
        #600_000;
        err_total++;
        results;
    end
endmodule : tb
